// >>> design/output_source_and_loop_config.sv
// register bank for output pair sources, divider sync and loop settings
// Function
// (R1) sync bit rising holds all pll-fed output dividers in reset
// (R2) sync bit falling releases dividers together and clears coarse phase
// (R3) pair two and three source codes: pll, ref0, ref1, crystal; reset 00
// (R4) software avoids direct reference source above 250 MHz
// (R5) software writes zero to reserved bits, ignores their read value
// (R6) pump current code picks 110 to 880 microamps; reset 100
// (R7) series resistor code picks 330 to 1790 ohms; reset 01
// (R8) parallel capacitor code picks 40 to 200 picofarads; reset 01
// (R9) second pole bit picks post resistor 497 or 1580 ohms; reset 1
// (R10) time digitizer off bit disables converter when one; reset 0
// (R11) synthesizer only bit runs pll from crystal alone; reset 0
// (R12) software forces free-run loop state with synthesizer only mode
// (R13) lock counter width bit picks 20 or 16 bit accumulator; reset 1
// (R14) lock override bit selects manual lock control when one; reset 0
// (R15) manual oscillator choice 000 first vco, 001 second vco
// (R16) manual lock value feeds vco lock control in manual mode
// (R17) fields hold last write, read back, reset to defaults
`timescale 1ns/1ps
module output_source_and_loop_config (
  input wire logic REF_CLK, // 40 MHz system clock
  input wire logic SRST, // synchronous reset, active high
  input wire logic REG_WR, // register write strobe
  input wire logic [7:0] REG_ADDR, // register address
  input wire logic [7:0] REG_WDATA, // write data
  output logic [7:0] REG_RDATA, // registered read data
  output logic DIV_HOLD, // pll-fed output dividers in reset
  output logic PHASE_CLEAR, // coarse phase reset pulse
  output logic [1:0] PAIR2_SOURCE_PICK, // pair two source
  output logic [1:0] PAIR3_SOURCE_PICK, // pair three source
  output logic [7:0] PAIR2_ROUTE, // pair two one-hot source route
  output logic [7:0] PAIR3_ROUTE, // pair three one-hot source route
  output logic [2:0] PUMP_CURRENT_CODE, // charge pump current
  output logic [1:0] FILTER_SERIES_RESISTOR, // loop filter series r
  output logic [1:0] FILTER_PARALLEL_CAPACITOR, // loop filter parallel c
  output logic SECOND_POLE_PICK, // post resistor pick
  output logic TIME_DIGITIZER_OFF, // converter disable
  output logic SYNTHESIZER_ONLY, // crystal-only synthesis
  output logic LOCK_COUNTER_WIDTH, // 1 = 16-bit lock counter
  output logic LOCK_MANUAL_OVERRIDE, // manual lock mode
  output logic VCO_SECOND_SELECT, // second vco in use (manual)
  output logic [4:0] MANUAL_LOCK_VALUE, // lock control value
  output logic [4:0] LOCK_CONTROL // applied lock control value
);
  logic [7:0] src_sel, src_misc, filter, mode, manual, loop_misc;
  logic hold_w, clear_w;
  wire sync_w = src_sel[loopcfg_pkg::SYNC_BIT];

  cfg_byte_reg #(.ADDR(loopcfg_pkg::ADDR_SRC_SEL),
    .MASK(loopcfg_pkg::MASK_SRC_SEL),
    .RESET_VALUE(loopcfg_pkg::RST_SRC_SEL)) u_src_sel ( // [R3]
    .clk(REF_CLK), .srst(SRST), .wr_en(REG_WR), .addr(REG_ADDR),
    .wdata(REG_WDATA), .value(src_sel));
  cfg_byte_reg #(.ADDR(loopcfg_pkg::ADDR_SRC_MISC),
    .MASK(loopcfg_pkg::MASK_SRC_MISC),
    .RESET_VALUE(loopcfg_pkg::RST_SRC_MISC)) u_src_misc (
    .clk(REF_CLK), .srst(SRST), .wr_en(REG_WR), .addr(REG_ADDR),
    .wdata(REG_WDATA), .value(src_misc));
  cfg_byte_reg #(.ADDR(loopcfg_pkg::ADDR_FILTER),
    .MASK(loopcfg_pkg::MASK_FILTER),
    .RESET_VALUE(loopcfg_pkg::RST_FILTER)) u_filter ( // [R6] [R7] [R8] [R9]
    .clk(REF_CLK), .srst(SRST), .wr_en(REG_WR), .addr(REG_ADDR),
    .wdata(REG_WDATA), .value(filter));
  cfg_byte_reg #(.ADDR(loopcfg_pkg::ADDR_MODE),
    .MASK(loopcfg_pkg::MASK_MODE),
    .RESET_VALUE(loopcfg_pkg::RST_MODE)) u_mode ( // [R10] [R11] [R13] [R14]
    .clk(REF_CLK), .srst(SRST), .wr_en(REG_WR), .addr(REG_ADDR),
    .wdata(REG_WDATA), .value(mode));
  cfg_byte_reg #(.ADDR(loopcfg_pkg::ADDR_MANUAL),
    .MASK(loopcfg_pkg::MASK_MANUAL),
    .RESET_VALUE(loopcfg_pkg::RST_MANUAL)) u_manual ( // [R16]
    .clk(REF_CLK), .srst(SRST), .wr_en(REG_WR), .addr(REG_ADDR),
    .wdata(REG_WDATA), .value(manual));
  cfg_byte_reg #(.ADDR(loopcfg_pkg::ADDR_LOOP_MISC),
    .MASK(loopcfg_pkg::MASK_LOOP_MISC),
    .RESET_VALUE(loopcfg_pkg::RST_LOOP_MISC)) u_loop_misc (
    .clk(REF_CLK), .srst(SRST), .wr_en(REG_WR), .addr(REG_ADDR),
    .wdata(REG_WDATA), .value(loop_misc));

  divider_sync_ctrl u_sync (
    .clk(REF_CLK),
    .srst(SRST),
    .sync_bit(sync_w),
    .hold(hold_w),
    .phase_clear(clear_w)
  );

  // one-hot route: bit0 pll, bit1 ref0, bit2 ref1, bit3 crystal
  function automatic logic [7:0] route_of(input logic [1:0] code);
    route_of = 8'h00;
    case (code)
      loopcfg_pkg::SRC_PLL: route_of = 8'h01;
      loopcfg_pkg::SRC_REF0: route_of = 8'h02;
      loopcfg_pkg::SRC_REF1: route_of = 8'h04;
      default: route_of = 8'h08;
    endcase
  endfunction : route_of

  wire [1:0] pair2_w = src_sel[loopcfg_pkg::PAIR2_LSB +: 2];
  wire [1:0] pair3_w = src_sel[loopcfg_pkg::PAIR3_LSB +: 2];
  wire manual_w = mode[loopcfg_pkg::OVR_BIT];
  wire [2:0] osc_w = manual[loopcfg_pkg::OSC_LSB +: 3];
  wire [4:0] lockv_w = manual[loopcfg_pkg::LOCKV_LSB +: 5];
  // reserved vco codes fall back to the first oscillator
  wire second_w = manual_w && (osc_w == loopcfg_pkg::OSC_SECOND);
  wire [4:0] lockctl_w = manual_w ? lockv_w : 5'h00;

  logic [7:0] rdata_d;
  always_comb begin
    case (REG_ADDR)
      loopcfg_pkg::ADDR_SRC_SEL: rdata_d = src_sel;
      loopcfg_pkg::ADDR_SRC_MISC: rdata_d = src_misc;
      loopcfg_pkg::ADDR_FILTER: rdata_d = filter;
      loopcfg_pkg::ADDR_MODE: rdata_d = mode;
      loopcfg_pkg::ADDR_MANUAL: rdata_d = manual;
      loopcfg_pkg::ADDR_LOOP_MISC: rdata_d = loop_misc;
      default: rdata_d = 8'h00; // [R5]
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      REG_RDATA <= 8'h00;
      DIV_HOLD <= 1'b0;
      PHASE_CLEAR <= 1'b0;
      PAIR2_SOURCE_PICK <= 2'h0;
      PAIR3_SOURCE_PICK <= 2'h0;
      PAIR2_ROUTE <= 8'h01;
      PAIR3_ROUTE <= 8'h01;
      PUMP_CURRENT_CODE <= 3'h4;
      FILTER_SERIES_RESISTOR <= 2'h1;
      FILTER_PARALLEL_CAPACITOR <= 2'h1;
      SECOND_POLE_PICK <= 1'b1;
      TIME_DIGITIZER_OFF <= 1'b0;
      SYNTHESIZER_ONLY <= 1'b0;
      LOCK_COUNTER_WIDTH <= 1'b1;
      LOCK_MANUAL_OVERRIDE <= 1'b0;
      VCO_SECOND_SELECT <= 1'b0;
      MANUAL_LOCK_VALUE <= 5'h0b;
      LOCK_CONTROL <= 5'h00;
    end else begin
      REG_RDATA <= rdata_d; // [R17]
      DIV_HOLD <= hold_w; // [R1]
      PHASE_CLEAR <= clear_w; // [R2]
      PAIR2_SOURCE_PICK <= pair2_w; // [R3]
      PAIR3_SOURCE_PICK <= pair3_w; // [R3]
      PAIR2_ROUTE <= route_of(pair2_w); // [R3]
      PAIR3_ROUTE <= route_of(pair3_w); // [R3]
      PUMP_CURRENT_CODE <= filter[loopcfg_pkg::PUMP_LSB +: 3]; // [R6]
      FILTER_SERIES_RESISTOR <= filter[loopcfg_pkg::SER_LSB +: 2]; // [R7]
      FILTER_PARALLEL_CAPACITOR <= filter[loopcfg_pkg::PAR_LSB +: 2]; // [R8]
      SECOND_POLE_PICK <= filter[loopcfg_pkg::POLE_BIT]; // [R9]
      TIME_DIGITIZER_OFF <= mode[loopcfg_pkg::TDC_BIT]; // [R10]
      SYNTHESIZER_ONLY <= mode[loopcfg_pkg::SYN_BIT]; // [R11]
      LOCK_COUNTER_WIDTH <= mode[loopcfg_pkg::CNT_BIT]; // [R13]
      LOCK_MANUAL_OVERRIDE <= manual_w; // [R14]
      VCO_SECOND_SELECT <= second_w; // [R15]
      MANUAL_LOCK_VALUE <= lockv_w; // [R16]
      LOCK_CONTROL <= lockctl_w; // [R16]
    end
  end

  // hold shows two edges after the stored bit rises: one edge for the
  // sequencer state, one for the output flop
  hold_after_rise_a: assert property ( // [R1]
    @(posedge REF_CLK) disable iff (SRST)
    $rose(sync_w) |-> ##2 DIV_HOLD)
    else $error("dividers not held after sync rise");
  release_clear_a: assert property ( // [R2]
    @(posedge REF_CLK) disable iff (SRST)
    (DIV_HOLD && $fell(sync_w)) |-> ##2 (PHASE_CLEAR && !DIV_HOLD))
    else $error("release without phase clear");
  clear_one_cycle_a: assert property ( // [R2]
    @(posedge REF_CLK) disable iff (SRST)
    PHASE_CLEAR |=> !PHASE_CLEAR)
    else $error("phase clear longer than one cycle");
  route_onehot_a: assert property ( // [R3]
    @(posedge REF_CLK) disable iff (SRST)
    PAIR2_ROUTE == (8'h01 << PAIR2_SOURCE_PICK))
    else $error("pair two route mismatch");
  route3_onehot_a: assert property ( // [R3]
    @(posedge REF_CLK) disable iff (SRST)
    PAIR3_ROUTE == (8'h01 << PAIR3_SOURCE_PICK))
    else $error("pair three route mismatch");
  pair_follows_a: assert property ( // [R3]
    @(posedge REF_CLK) disable iff (SRST)
    (REG_WR && REG_ADDR == loopcfg_pkg::ADDR_SRC_SEL) |-> ##2
    (PAIR2_SOURCE_PICK == $past(REG_WDATA[1:0], 2)
    && PAIR3_SOURCE_PICK == $past(REG_WDATA[5:4], 2)))
    else $error("pair source not applied");
  write_readback_a: assert property ( // [R17]
    @(posedge REF_CLK) disable iff (SRST)
    (REG_WR && REG_ADDR == loopcfg_pkg::ADDR_FILTER)
    ##1 (!REG_WR && REG_ADDR == loopcfg_pkg::ADDR_FILTER)
    |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("filter register readback wrong");
  pump_follows_a: assert property ( // [R6]
    @(posedge REF_CLK) disable iff (SRST)
    (REG_WR && REG_ADDR == loopcfg_pkg::ADDR_FILTER) |-> ##2
    PUMP_CURRENT_CODE == $past(REG_WDATA[7:5], 2))
    else $error("pump current not applied");
  filter_fields_a: assert property ( // [R7] [R8] [R9]
    @(posedge REF_CLK) disable iff (SRST)
    (REG_WR && REG_ADDR == loopcfg_pkg::ADDR_FILTER) |-> ##2
    (FILTER_SERIES_RESISTOR == $past(REG_WDATA[4:3], 2)
    && FILTER_PARALLEL_CAPACITOR == $past(REG_WDATA[2:1], 2)
    && SECOND_POLE_PICK == $past(REG_WDATA[0], 2)))
    else $error("loop filter setting not applied");
  mode_follows_a: assert property ( // [R10] [R11] [R13]
    @(posedge REF_CLK) disable iff (SRST)
    (REG_WR && REG_ADDR == loopcfg_pkg::ADDR_MODE) |-> ##2
    (TIME_DIGITIZER_OFF == $past(REG_WDATA[4], 2)
    && SYNTHESIZER_ONLY == $past(REG_WDATA[3], 2)
    && LOCK_COUNTER_WIDTH == $past(REG_WDATA[1], 2)
    && LOCK_MANUAL_OVERRIDE == $past(REG_WDATA[0], 2)))
    else $error("loop mode setting not applied");
  manual_gate_a: assert property ( // [R14]
    @(posedge REF_CLK) disable iff (SRST)
    !LOCK_MANUAL_OVERRIDE |-> (LOCK_CONTROL == 5'h00 && !VCO_SECOND_SELECT))
    else $error("lock control active in automatic mode");
  manual_value_a: assert property ( // [R16]
    @(posedge REF_CLK) disable iff (SRST)
    LOCK_MANUAL_OVERRIDE |-> LOCK_CONTROL == MANUAL_LOCK_VALUE)
    else $error("manual lock value not applied");
  // reserved oscillator codes must never reach the second vco
  vco_second_a: assert property ( // [R15]
    @(posedge REF_CLK) disable iff (SRST)
    (REG_WR && REG_ADDR == loopcfg_pkg::ADDR_MANUAL) |-> ##2
    VCO_SECOND_SELECT == (LOCK_MANUAL_OVERRIDE
    && $past(REG_WDATA[7:5], 2) == loopcfg_pkg::OSC_SECOND))
    else $error("second vco pick wrong");
  reset_defaults_a: assert property ( // [R9] [R6] [R13]
    @(posedge REF_CLK)
    SRST |=> (SECOND_POLE_PICK && LOCK_COUNTER_WIDTH
    && MANUAL_LOCK_VALUE == 5'h0b && FILTER_SERIES_RESISTOR == 2'h1
    && PUMP_CURRENT_CODE == 3'h4 && FILTER_PARALLEL_CAPACITOR == 2'h1
    && PAIR2_SOURCE_PICK == 2'h0 && !SYNTHESIZER_ONLY && !DIV_HOLD))
    else $error("reset defaults wrong");
endmodule : output_source_and_loop_config

// >>> design/loopcfg_pkg.sv
// constants for the output source and loop configuration registers
package loopcfg_pkg;
  localparam logic [7:0] ADDR_SRC_SEL = 8'h63;
  localparam logic [7:0] ADDR_RSVD_A = 8'h64;
  localparam logic [7:0] ADDR_RSVD_B = 8'h65;
  localparam logic [7:0] ADDR_RSVD_C = 8'h66;
  localparam logic [7:0] ADDR_SRC_MISC = 8'h67;
  localparam logic [7:0] ADDR_FILTER = 8'h68;
  localparam logic [7:0] ADDR_MODE = 8'h69;
  localparam logic [7:0] ADDR_MANUAL = 8'h6a;
  localparam logic [7:0] ADDR_LOOP_MISC = 8'h6b;
  // field positions
  localparam int SYNC_BIT = 7;
  localparam int PAIR3_LSB = 4;
  localparam int PAIR2_LSB = 0;
  localparam int PUMP_LSB = 5;
  localparam int SER_LSB = 3;
  localparam int PAR_LSB = 1;
  localparam int POLE_BIT = 0;
  localparam int TDC_BIT = 4;
  localparam int SYN_BIT = 3;
  localparam int CNT_BIT = 1;
  localparam int OVR_BIT = 0;
  localparam int OSC_LSB = 5;
  localparam int LOCKV_LSB = 0;
  // writable masks per register
  localparam logic [7:0] MASK_SRC_SEL = 8'hb3;
  localparam logic [7:0] MASK_SRC_MISC = 8'hfc;
  localparam logic [7:0] MASK_FILTER = 8'hff;
  localparam logic [7:0] MASK_MODE = 8'h1b;
  localparam logic [7:0] MASK_MANUAL = 8'hff;
  localparam logic [7:0] MASK_LOOP_MISC = 8'he0;
  // reset values
  localparam logic [7:0] RST_SRC_SEL = 8'h00;
  localparam logic [7:0] RST_SRC_MISC = 8'ha0;
  localparam logic [7:0] RST_FILTER = 8'h8b;
  localparam logic [7:0] RST_MODE = 8'h02;
  localparam logic [7:0] RST_MANUAL = 8'h0b;
  localparam logic [7:0] RST_LOOP_MISC = 8'h20;
  // source codes
  localparam logic [1:0] SRC_PLL = 2'h0;
  localparam logic [1:0] SRC_REF0 = 2'h1;
  localparam logic [1:0] SRC_REF1 = 2'h2;
  localparam logic [1:0] SRC_XTAL = 2'h3;
  localparam logic [2:0] OSC_FIRST = 3'h0;
  localparam logic [2:0] OSC_SECOND = 3'h1;
  typedef enum logic [2:0] {
    SYNC_RUN = 3'b001,
    SYNC_HOLD = 3'b010,
    SYNC_RELEASE = 3'b100
  } sync_state_t;
endpackage : loopcfg_pkg

// >>> design/cfg_byte_reg.sv
// one eight-bit configuration register with write mask and reset value
`timescale 1ns/1ps
module cfg_byte_reg #(
  parameter logic [7:0] ADDR = 8'h00,
  parameter logic [7:0] MASK = 8'hff,
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic wr_en, // write strobe
  input wire logic [7:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  output logic [7:0] value // stored value
);
  logic [7:0] value_q;
  wire hit = wr_en && (addr == ADDR);
  // reserved positions never store, so they read back zero
  wire [7:0] value_d = hit ? (wdata & MASK) : value_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      value_q <= RESET_VALUE; // [R17]
    end else begin
      value_q <= value_d; // [R17]
    end
  end
  assign value = value_q;
endmodule : cfg_byte_reg

// >>> design/divider_sync_ctrl.sv
// release sequencer for the pll-fed output dividers
`timescale 1ns/1ps
module divider_sync_ctrl (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic sync_bit, // stored synchronization bit
  output logic hold, // dividers held in reset
  output logic phase_clear // one-cycle coarse phase clear
);
  loopcfg_pkg::sync_state_t state_q, state_d;
  logic sync_prev_q;
  wire rise = sync_bit && !sync_prev_q;
  wire fall = !sync_bit && sync_prev_q;
  always_comb begin
    state_d = state_q;
    case (state_q)
      loopcfg_pkg::SYNC_RUN: begin
        if (rise) state_d = loopcfg_pkg::SYNC_HOLD; // [R1]
      end
      loopcfg_pkg::SYNC_HOLD: begin
        if (fall) state_d = loopcfg_pkg::SYNC_RELEASE; // [R2]
      end
      loopcfg_pkg::SYNC_RELEASE: begin
        state_d = rise ? loopcfg_pkg::SYNC_HOLD : loopcfg_pkg::SYNC_RUN;
      end
      default: state_d = loopcfg_pkg::SYNC_RUN;
    endcase
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= loopcfg_pkg::SYNC_RUN;
      sync_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sync_prev_q <= sync_bit;
    end
  end
  assign hold = (state_q == loopcfg_pkg::SYNC_HOLD);
  assign phase_clear = (state_q == loopcfg_pkg::SYNC_RELEASE);
endmodule : divider_sync_ctrl

// >>> dv/output_source_and_loop_config_tb_top.sv
// self-checking bench for the output source and loop configuration bank
`timescale 1ns/1ps
module output_source_and_loop_config_tb_top;
  typedef struct {int sel; logic [7:0] exp;} note_t;
  logic REF_CLK = 1'b0;
  logic SRST = 1'b1;
  logic REG_WR = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic [7:0] REG_RDATA, PAIR2_ROUTE, PAIR3_ROUTE;
  logic DIV_HOLD, PHASE_CLEAR, SECOND_POLE_PICK, TIME_DIGITIZER_OFF;
  logic SYNTHESIZER_ONLY, LOCK_COUNTER_WIDTH, LOCK_MANUAL_OVERRIDE;
  logic VCO_SECOND_SELECT;
  logic [1:0] PAIR2_SOURCE_PICK, PAIR3_SOURCE_PICK;
  logic [1:0] FILTER_SERIES_RESISTOR, FILTER_PARALLEL_CAPACITOR;
  logic [2:0] PUMP_CURRENT_CODE;
  logic [4:0] MANUAL_LOCK_VALUE, LOCK_CONTROL;
  int err_count = 0;
  int compares = 0;
  note_t notes[$];
  event chk_ev;
  logic [7:0] m[9];
  // reserved registers store nothing, so their mask and default are zero
  logic [7:0] mk[9] = '{loopcfg_pkg::MASK_SRC_SEL, 8'h00, 8'h00, 8'h00,
    loopcfg_pkg::MASK_SRC_MISC, loopcfg_pkg::MASK_FILTER,
    loopcfg_pkg::MASK_MODE, loopcfg_pkg::MASK_MANUAL,
    loopcfg_pkg::MASK_LOOP_MISC};
  logic [7:0] rv[9] = '{loopcfg_pkg::RST_SRC_SEL, 8'h00, 8'h00, 8'h00,
    loopcfg_pkg::RST_SRC_MISC, loopcfg_pkg::RST_FILTER,
    loopcfg_pkg::RST_MODE, loopcfg_pkg::RST_MANUAL,
    loopcfg_pkg::RST_LOOP_MISC};
  string nm[18] = '{"rdata", "div_hold", "phase_clear", "pair2", "pair3",
    "route2", "route3", "pump", "series_r", "parallel_c", "pole", "tdc_off",
    "syn_only", "cnt_width", "override", "vco2", "lock_value", "lock_ctl"};

  output_source_and_loop_config output_source_and_loop_config_i (.*);

  always #12.5 REF_CLK = ~REF_CLK;

  function automatic logic [7:0] obs(int sel);
    case (sel)
      0: return REG_RDATA;
      1: return {7'h00, DIV_HOLD};
      2: return {7'h00, PHASE_CLEAR};
      3: return {6'h00, PAIR2_SOURCE_PICK};
      4: return {6'h00, PAIR3_SOURCE_PICK};
      5: return PAIR2_ROUTE;
      6: return PAIR3_ROUTE;
      7: return {5'h00, PUMP_CURRENT_CODE};
      8: return {6'h00, FILTER_SERIES_RESISTOR};
      9: return {6'h00, FILTER_PARALLEL_CAPACITOR};
      10: return {7'h00, SECOND_POLE_PICK};
      11: return {7'h00, TIME_DIGITIZER_OFF};
      12: return {7'h00, SYNTHESIZER_ONLY};
      13: return {7'h00, LOCK_COUNTER_WIDTH};
      14: return {7'h00, LOCK_MANUAL_OVERRIDE};
      15: return {7'h00, VCO_SECOND_SELECT};
      16: return {3'h0, MANUAL_LOCK_VALUE};
      default: return {3'h0, LOCK_CONTROL};
    endcase
  endfunction : obs

  task automatic chk(string name, logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // monitor drains every pending note at the moment it is signalled
  initial forever begin
    @(chk_ev);
    while (notes.size() > 0) begin
      note_t n;
      n = notes.pop_front();
      chk(nm[n.sel], obs(n.sel), n.exp);
    end
  end

  function automatic void note(int sel, logic [7:0] exp);
    notes.push_back(note_t'{sel, exp});
  endfunction : note

  // strobe stays high between writes so back-to-back writes never glitch
  task automatic wr(logic [7:0] a, logic [7:0] d);
    int i;
    i = int'(a) - 8'h63;
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(posedge REF_CLK) #1;
    if (i >= 0 && i < 9) m[i] = (m[i] & ~mk[i]) | (d & mk[i]);
  endtask : wr

  task automatic idle();
    REG_WR = 1'b0;
    @(posedge REF_CLK) #1;
  endtask : idle

  task automatic rd_all();
    for (int a = 8'h60; a < 8'h70; a++) begin
      REG_ADDR = 8'(a);
      @(posedge REF_CLK) #1;
      note(0, (a >= 8'h63 && a <= 8'h6b) ? m[a - 8'h63] : 8'h00);
      ->chk_ev;
    end
  endtask : rd_all

  task automatic chk_all();
    note(1, {7'h00, m[0][7]});
    note(2, 8'h00);
    note(3, {6'h00, m[0][1:0]});
    note(4, {6'h00, m[0][5:4]});
    note(5, 8'h01 << m[0][1:0]);
    note(6, 8'h01 << m[0][5:4]);
    note(7, {5'h00, m[5][7:5]});
    note(8, {6'h00, m[5][4:3]});
    note(9, {6'h00, m[5][2:1]});
    note(10, {7'h00, m[5][0]});
    note(11, {7'h00, m[6][4]});
    note(12, {7'h00, m[6][3]});
    note(13, {7'h00, m[6][1]});
    note(14, {7'h00, m[6][0]});
    note(15, {7'h00, m[6][0] && m[7][7:5] == 3'h1});
    note(16, {3'h0, m[7][4:0]});
    note(17, m[6][0] ? {3'h0, m[7][4:0]} : 8'h00);
    ->chk_ev;
  endtask : chk_all

  task automatic do_reset();
    SRST = 1'b1;
    repeat (3) @(posedge REF_CLK);
    #1 SRST = 1'b0;
    m = rv;
  endtask : do_reset

  task automatic finish_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  initial begin
    #(5000 * 25);
    err_count++;
    finish_test();
  end

  initial begin
    logic [7:0] a, d;
    void'($urandom(32'h0746));
    do_reset();
    chk_all();
    rd_all();
    // sync hold and release, checked cycle by cycle
    wr(8'h63, 8'h80);
    idle();
    note(1, 8'h00);
    ->chk_ev;
    @(posedge REF_CLK) #1;
    note(1, 8'h01);
    ->chk_ev;
    wr(8'h63, 8'h00);
    idle();
    note(1, 8'h01);
    ->chk_ev;
    @(posedge REF_CLK) #1;
    note(1, 8'h00);
    note(2, 8'h01);
    ->chk_ev;
    @(posedge REF_CLK) #1;
    note(2, 8'h00);
    ->chk_ev;
    // read data comes one cycle after the address settles
    wr(loopcfg_pkg::ADDR_FILTER, 8'($urandom));
    idle();
    note(0, m[5]);
    ->chk_ev;
    // every code of the pair, pump, parallel c and oscillator fields, override on so vco pick is visible
    for (int i = 0; i < 8; i++) begin
      // bench references count as slow enough to route directly
      wr(8'h63, {2'h0, i[1:0], 2'h0, 2'(i + 1)});
      wr(8'h68, {i[2:0], 5'(~i)});
      // synthesizer-only pairs with free-run state in another bank
      wr(8'h69, {3'h0, i[0], i[1], 1'b0, i[2], 1'b1});
      wr(8'h6a, {i[2:0], 5'(i * 5)});
      wr(8'h6b, 8'(i << 5));
      wr(8'h67, 8'(i * 8'h24));
      idle();
      chk_all();
    end
    // random traffic to mapped and unmapped addresses, reserved bits kept zero
    repeat (4) begin
      repeat (40) begin
        a = 8'h60 + 8'($urandom_range(15));
        d = 8'($urandom);
        // reserved positions are written as zero
        if (a >= 8'h63 && a <= 8'h6b) d &= mk[a - 8'h63];
        if (a == 8'h63) d[7] = 1'b0;
        wr(a, d);
      end
      idle();
      chk_all();
      rd_all();
    end
    do_reset();
    chk_all();
    rd_all();
    // let the monitor drain the last note before the verdict
    @(posedge REF_CLK) #1;
    finish_test();
  end
endmodule : output_source_and_loop_config_tb_top
